// ### pci_target_pkg.sv
package pci_target_pkg;

  // bus commands carried on the command/byte-enable lines in the address phase
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

  // field positions and constants
  localparam int CMD_WRITE_BIT = 0;
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [3:0] CMD_RESET = 4'h0;
  localparam logic [3:0] BE_RESET = 4'h0;

  // target sequencer states, gray coded along idle-data-ready-turn
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_DATA = 3'h1,
    S_READY = 3'h3,
    S_TURN = 3'h7,
    S_STOP = 3'h2
  } tgt_state_t;

endpackage

// ### bus_parity.sv
`timescale 1ns/1ps
// registered even parity over one bus cycle of address/data and command lines
module bus_parity
  import pci_target_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_i,
  output logic par_o
);

  logic next_par;

  // even parity: the xor of all 36 lines plus par is zero
  always_comb begin
    next_par = ^{ad_i, cbe_i};
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      par_o <= 1'b0;
    end else begin
      par_o <= next_par;
    end
  end

endmodule

// ### pci_target_bus_interface.sv
`timescale 1ns/1ps
// Functional notes
// - address and data share the 32 ad lines, both halves
// - one address phase, then one or more data phases, tracked by the sequencer
// - command/byte-enable lines give command in address phase, byte enables after
// - device select driven only after our own address decode, else floated
// - configuration accesses answered only while the init select is high
// - interrupt request is a level, open-drain, active-low output
// - even parity over ad and command lines, valid one clock after
// - parity of received write data checked, parity error driven on mismatch
// - target only: bus request never driven, grant ignored
// - bus reset returns sequencer, signals and registers to defaults
// - target may assert stop to end the current transaction
// - every bus signal is timed by the single bus clock
// - target ready asserted when able; wait states by holding it high
// - address parity errors reported on open-drain system error
module pci_target_bus_interface
  import pci_target_pkg::*;
#(
  parameter int DEC_BITS = 8
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  input wire logic [3:0] cbe_b_i,
  input wire logic par_i,
  output logic par_o,
  output logic par_oe_o,
  input wire logic frame_b_i,
  input wire logic irdy_b_i,
  input wire logic idsel_i,
  output logic trdy_b_o,
  output logic trdy_oe_o,
  output logic devsel_b_o,
  output logic devsel_oe_o,
  output logic stop_b_o,
  output logic stop_oe_o,
  output logic perr_b_o,
  output logic perr_oe_o,
  output logic serr_b_o,
  output logic serr_oe_o,
  output logic inta_b_o,
  output logic inta_oe_o,
  output logic req_b_o,
  output logic req_oe_o,
  input wire logic gnt_b_i,
  input wire logic [31:0] bar_base_i,
  input wire logic perr_en_i,
  input wire logic serr_en_i,
  input wire logic irq_i,
  output logic usr_req_o,
  output logic usr_write_o,
  output logic usr_cfg_o,
  output logic [31:0] usr_addr_o,
  input wire logic usr_ack_i,
  input wire logic [31:0] usr_rdata_i,
  input wire logic usr_stop_i,
  output logic usr_wr_o,
  output logic [31:0] usr_wdata_o,
  output logic [3:0] usr_be_o
);

  // odd command codes are the write commands
  function automatic logic is_write(input logic [3:0] cmd_f);
    is_write = cmd_f[CMD_WRITE_BIT];
  endfunction

  // address decode: config type 0 with select, or memory/io inside our window
  function automatic logic dec_hit(input logic [31:0] a, input logic [3:0] c,
                                   input logic sel, input logic [31:0] base);
    logic win;
    win = (a[31:DEC_BITS] == base[31:DEC_BITS]);
    case (c)
      CMD_CFG_RD, CMD_CFG_WR: dec_hit = sel && (a[1:0] == CFG_TYPE0);
      CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR: dec_hit = win;
      CMD_MEM_RD_MULT, CMD_MEM_RD_LINE, CMD_MEM_WR_INV: dec_hit = win;
      default: dec_hit = 1'b0;
    endcase
  endfunction

  tgt_state_t state, next_state;
  logic [31:0] addr, next_addr;
  logic [3:0] cmd, next_cmd;
  logic cfg, next_cfg;
  logic [31:0] rdata, next_rdata;
  logic stop_req, next_stop_req;
  logic frame_prev, next_frame_prev;
  logic [31:0] wdata, next_wdata;
  logic [3:0] be, next_be;
  logic wr_pulse, next_wr_pulse;
  logic addr_chk, next_addr_chk;
  logic data_chk, next_data_chk;
  logic perr_act, next_perr_act;
  logic perr_rel, next_perr_rel;
  logic serr_act, next_serr_act;
  logic par_oe, next_par_oe;
  logic inta, next_inta;
  logic [31:0] ad_bus;
  logic par_bus;
  logic start;
  logic xfer;
  logic par_bad;
  logic drive_ad;

  // a new address phase: frame falls while the bus was idle
  assign start = (state == S_IDLE) && !frame_b_i && frame_prev;
  // both ready lines low completes a data phase
  assign xfer = (state == S_READY) && !irdy_b_i;
  assign drive_ad = ((state == S_DATA) || (state == S_READY)) && !is_write(cmd);
  // parity over what is really on the lines, ours when we drive them
  assign ad_bus = drive_ad ? rdata : ad_i;
  assign par_bad = (par_i != par_bus);

  bus_parity u_parity (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ad_i(ad_bus),
    .cbe_i(cbe_b_i),
    .par_o(par_bus)
  );

  // sequencer next values; wait states come from the user side acknowledge
  always_comb begin
    next_state = state;
    next_addr = addr;
    next_cmd = cmd;
    next_cfg = cfg;
    next_rdata = rdata;
    next_stop_req = stop_req;
    next_wdata = wdata;
    next_be = be;
    next_wr_pulse = 1'b0;
    next_frame_prev = frame_b_i;
    case (state)
      S_IDLE: begin
        next_stop_req = 1'b0;
        if (start && dec_hit(ad_i, cbe_b_i, idsel_i, bar_base_i)) begin
          next_state = S_DATA;
          next_addr = ad_i;
          next_cmd = cbe_b_i;
          next_cfg = (cbe_b_i == CMD_CFG_RD) || (cbe_b_i == CMD_CFG_WR);
        end
      end
      S_DATA: begin
        // target ready stays high until the user side answers
        if (usr_ack_i) begin
          next_state = S_READY;
          next_rdata = usr_rdata_i;
          next_stop_req = usr_stop_i;
        end
      end
      S_READY: begin
        if (xfer) begin
          next_addr = addr + ADDR_STEP;
          next_wdata = ad_i;
          next_be = ~cbe_b_i;
          next_wr_pulse = is_write(cmd);
          if (frame_b_i) begin
            next_state = S_TURN;
          end else if (stop_req) begin
            next_state = S_STOP;
          end else begin
            next_state = S_DATA;
          end
        end
      end
      S_STOP: begin
        // hold stop until the initiator lets frame go
        if (frame_b_i) begin
          next_state = S_TURN;
        end
      end
      S_TURN: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // parity and error next values; checks sample one clock after the phase
  always_comb begin
    next_addr_chk = start;
    next_data_chk = xfer && is_write(cmd);
    next_perr_act = data_chk && par_bad && perr_en_i;
    next_perr_rel = perr_act; // drive high one cycle before floating
    next_serr_act = addr_chk && par_bad && serr_en_i;
    next_par_oe = drive_ad;
    next_inta = irq_i;
  end

  // single clock domain, rising edge, async active-low bus reset
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= S_IDLE;
      addr <= ADDR_RESET;
      cmd <= CMD_RESET;
      cfg <= 1'b0;
      rdata <= DATA_RESET;
      stop_req <= 1'b0;
      frame_prev <= 1'b1;
      wdata <= DATA_RESET;
      be <= BE_RESET;
      wr_pulse <= 1'b0;
      addr_chk <= 1'b0;
      data_chk <= 1'b0;
      perr_act <= 1'b0;
      perr_rel <= 1'b0;
      serr_act <= 1'b0;
      par_oe <= 1'b0;
      inta <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      cmd <= next_cmd;
      cfg <= next_cfg;
      rdata <= next_rdata;
      stop_req <= next_stop_req;
      frame_prev <= next_frame_prev;
      wdata <= next_wdata;
      be <= next_be;
      wr_pulse <= next_wr_pulse;
      addr_chk <= next_addr_chk;
      data_chk <= next_data_chk;
      perr_act <= next_perr_act;
      perr_rel <= next_perr_rel;
      serr_act <= next_serr_act;
      par_oe <= next_par_oe;
      inta <= next_inta;
    end
  end

  // control lines: driven from the data phase on, driven high for one turn cycle
  assign devsel_oe_o = (state != S_IDLE);
  assign devsel_b_o = !((state == S_DATA) || (state == S_READY) || (state == S_STOP));
  assign trdy_oe_o = (state != S_IDLE);
  assign trdy_b_o = (state != S_READY);
  assign stop_oe_o = (state != S_IDLE);
  assign stop_b_o = !(((state == S_READY) || (state == S_STOP)) && stop_req);

  // read data; driven together with devsel from the clock after the address phase, so no turnaround cycle
  assign ad_oe_o = drive_ad;
  assign ad_o = rdata;
  assign par_oe_o = par_oe;
  assign par_o = par_bus;

  // error lines; system error is open drain and never driven high
  assign perr_oe_o = perr_act || perr_rel;
  assign perr_b_o = !perr_act;
  assign serr_oe_o = serr_act;
  assign serr_b_o = 1'b0;

  // level interrupt: pull low while pending, otherwise let the pull-up win
  assign inta_oe_o = inta;
  assign inta_b_o = 1'b0;

  // no bus mastering: request floats forever and grant is never looked at
  assign req_oe_o = 1'b0;
  assign req_b_o = 1'b1;

  // user side; the request is a level held until acknowledged
  assign usr_req_o = (state == S_DATA);
  assign usr_write_o = is_write(cmd);
  assign usr_cfg_o = cfg;
  assign usr_addr_o = addr;
  assign usr_wr_o = wr_pulse;
  assign usr_wdata_o = wdata;
  assign usr_be_o = be;

endmodule

// ### pci_target_props_sva.sv
`timescale 1ns/1ps
module pci_target_props #(
  parameter int DEC_BITS = 8
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_b_i,
  input wire logic frame_b_i,
  input wire logic irq_i,
  input wire logic perr_en_i,
  input wire logic ad_oe_o,
  input wire logic par_o,
  input wire logic par_oe_o,
  input wire logic trdy_b_o,
  input wire logic trdy_oe_o,
  input wire logic devsel_b_o,
  input wire logic devsel_oe_o,
  input wire logic stop_b_o,
  input wire logic stop_oe_o,
  input wire logic perr_b_o,
  input wire logic perr_oe_o,
  input wire logic serr_b_o,
  input wire logic serr_oe_o,
  input wire logic inta_b_o,
  input wire logic inta_oe_o,
  input wire logic req_oe_o
);
  // one bus clock, so one default clock for every check and one default reset for all but the reset check
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_devsel_own_decode: assert property ($rose(devsel_oe_o) |-> !$past(frame_b_i) && $past(frame_b_i, 2))
    else $error("device select without a fresh address phase");
  a_trdy_under_devsel: assert property (trdy_oe_o && !trdy_b_o |-> devsel_oe_o && !devsel_b_o)
    else $error("target ready outside device select");
  a_stop_under_devsel: assert property (stop_oe_o && !stop_b_o |-> devsel_oe_o && !devsel_b_o)
    else $error("stop outside device select");
  a_no_bus_request: assert property (!req_oe_o)
    else $error("bus request driven");
  a_inta_level: assert property (irq_i [*2] |-> inta_oe_o && !inta_b_o)
    else $error("interrupt line not held low");
  a_parity_even: assert property (par_oe_o |-> par_o == ^{$past(ad_i), $past(cbe_b_i)})
    else $error("parity not even over previous cycle");
  a_perr_one_cycle: assert property (perr_oe_o && !perr_b_o |-> $past(perr_en_i) ##1 perr_oe_o && perr_b_o)
    else $error("parity error pulse malformed");
  a_serr_pulse: assert property (serr_oe_o |-> !serr_b_o ##1 !serr_oe_o)
    else $error("system error pulse malformed");
  a_turn_float: assert property (devsel_oe_o && $rose(devsel_b_o) |=> !(devsel_oe_o || trdy_oe_o || stop_oe_o || ad_oe_o))
    else $error("lines not floated after turnaround");
  // reset must win even though it disables everything else
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i |-> !(ad_oe_o || devsel_oe_o || trdy_oe_o || par_oe_o))
    else $error("bus driven during reset");
  c_transfer: cover property (trdy_oe_o && !trdy_b_o);
  c_serr: cover property (serr_oe_o);
  c_perr: cover property (perr_oe_o && !perr_b_o);
endmodule
bind pci_target_bus_interface pci_target_props #(.DEC_BITS(DEC_BITS)) u_props(.ref_clk_i, .rst_b_i,
  .ad_i, .cbe_b_i, .frame_b_i, .irq_i, .perr_en_i, .ad_oe_o, .par_o, .par_oe_o, .trdy_b_o,
  .trdy_oe_o, .devsel_b_o, .devsel_oe_o, .stop_b_o, .stop_oe_o, .perr_b_o, .perr_oe_o,
  .serr_b_o, .serr_oe_o, .inta_b_o, .inta_oe_o, .req_oe_o);

// ### pci_host_model.sv
`timescale 1ns/1ps
// initiator: one address phase then one final data phase per call
module pci_host_model (
  input wire logic clk_i,
  input wire logic [31:0] ad_i,
  input wire logic trdy_b_i,
  output logic [31:0] ad_o,
  output logic [3:0] cbe_b_o,
  output logic par_o,
  output logic frame_b_o,
  output logic irdy_b_o,
  output logic idsel_o
);
  initial begin
    ad_o = 32'h0;
    cbe_b_o = 4'hF;
    par_o = 1'b0;
    frame_b_o = 1'b1;
    irdy_b_o = 1'b1;
    idsel_o = 1'b0;
  end
  // bad[0] spoils address parity, bad[1] spoils write data parity
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] adr, input logic [31:0] wd,
                      input logic sel, input logic [1:0] bad, output logic [31:0] rd,
                      output logic hit);
    int n;
    @(posedge clk_i);
    frame_b_o <= 1'b0;
    ad_o <= adr;
    cbe_b_o <= cmd;
    idsel_o <= sel;
    @(posedge clk_i);
    frame_b_o <= 1'b1;
    irdy_b_o <= 1'b0;
    par_o <= ^{adr, cmd} ^ bad[0];
    ad_o <= cmd[0] ? wd : ~adr; // a read leaves garbage, never the old address
    cbe_b_o <= 4'h0;
    idsel_o <= 1'b0;
    for (n = 0; n < 16; n++) begin
      @(negedge clk_i);
      if (trdy_b_i === 1'b0) break;
    end
    hit = (n < 16);
    rd = ad_i;
    @(posedge clk_i);
    irdy_b_o <= 1'b1;
    par_o <= ^{wd, 4'h0} ^ bad[1];
    ad_o <= ~ad_o;
    cbe_b_o <= 4'hF;
    @(posedge clk_i);
    par_o <= ~par_o;
  endtask
endmodule

// ### pci_target_bus_interface_tb.sv
`timescale 1ns/1ps
module pci_target_bus_interface_tb;
  import pci_target_pkg::*;
  localparam logic [31:0] BASE = 32'h8000_1200;
  localparam logic [31:0] RDATA = 32'hA5C3_0F96;
  logic ref_clk_i, rst_b_i, par_o, par_oe_o, frame_b_i, irdy_b_i, idsel_i, ad_oe_o, h_par, hit;
  logic trdy_b_o, trdy_oe_o, devsel_b_o, devsel_oe_o, stop_b_o, stop_oe_o, perr_b_o, perr_oe_o;
  logic serr_b_o, serr_oe_o, inta_b_o, inta_oe_o, req_b_o, req_oe_o, gnt_b_i, perr_en_i;
  logic serr_en_i, irq_i, usr_req_o, usr_ack_i, usr_stop_i, usr_wr_o;
  logic [31:0] ad_o, h_ad, bar_base_i, usr_rdata_i, usr_wdata_o, wd_cap, rd;
  logic [31:0] usr_addr_o, addr_cap;
  logic usr_write_o, usr_cfg_o, write_cap, cfg_cap;
  logic [3:0] cbe_b_i, usr_be_o, be_cap;
  logic [3:0] cmds [9] = '{CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_CFG_RD,
                           CMD_CFG_WR, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE, CMD_MEM_WR_INV};
  int miscompares = 0, n_compared = 0, perr_cnt = 0, serr_cnt = 0, stop_cnt = 0;
  // the device wins the shared lines whenever it enables them
  wire logic [31:0] ad_w = ad_oe_o ? ad_o : h_ad;
  wire logic par_w = par_oe_o ? par_o : h_par;
  pci_target_bus_interface #(.DEC_BITS(8)) u_dut(.ref_clk_i, .rst_b_i, .ad_i(ad_w), .ad_o,
    .ad_oe_o, .cbe_b_i, .par_i(par_w), .par_o, .par_oe_o, .frame_b_i, .irdy_b_i, .idsel_i,
    .trdy_b_o, .trdy_oe_o, .devsel_b_o, .devsel_oe_o, .stop_b_o, .stop_oe_o, .perr_b_o,
    .perr_oe_o, .serr_b_o, .serr_oe_o, .inta_b_o, .inta_oe_o, .req_b_o, .req_oe_o, .gnt_b_i,
    .bar_base_i, .perr_en_i, .serr_en_i, .irq_i, .usr_req_o, .usr_write_o, .usr_cfg_o,
    .usr_addr_o, .usr_ack_i, .usr_rdata_i, .usr_stop_i, .usr_wr_o, .usr_wdata_o, .usr_be_o);
  pci_host_model u_host(.clk_i(ref_clk_i), .ad_i(ad_w), .trdy_b_i(trdy_b_o), .ad_o(h_ad),
    .cbe_b_o(cbe_b_i), .par_o(h_par), .frame_b_o(frame_b_i), .irdy_b_o(irdy_b_i),
    .idsel_o(idsel_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // user side acks one cycle late, so every data phase gets two wait states
  always @(posedge ref_clk_i) begin
    usr_ack_i <= usr_req_o & ~usr_ack_i;
    // request qualifiers are taken while the request waits for its answer
    if (usr_req_o && !usr_ack_i) begin
      addr_cap <= usr_addr_o;
      write_cap <= usr_write_o;
      cfg_cap <= usr_cfg_o;
    end
    if (usr_wr_o) wd_cap <= usr_wdata_o;
    if (usr_wr_o) be_cap <= usr_be_o;
    if (perr_oe_o && !perr_b_o) perr_cnt++;
    if (serr_oe_o && !serr_b_o) serr_cnt++;
    if (stop_oe_o && !stop_b_o) stop_cnt++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_read(input logic stp);
    int s0 = stop_cnt;
    usr_stop_i <= stp;
    u_host.xfer(CMD_MEM_RD, BASE | 32'h10, 32'h0, 1'b0, 2'b00, rd, hit);
    usr_stop_i <= 1'b0;
    chk(rd, RDATA);
    chk(addr_cap, BASE | 32'h10);
    chk({write_cap, cfg_cap}, 2'b00);
    chk(hit, 1'b1);
    chk(stop_cnt != s0, stp);
  endtask
  task automatic t_write();
    int p0;
    for (int b = 0; b < 3; b++) begin
      p0 = perr_cnt;
      perr_en_i <= (b != 2);
      u_host.xfer(CMD_MEM_WR, BASE | 32'h24, 32'h1234_ABC0 + b, 1'b0, (b != 0) ? 2'b10 : 2'b00,
                  rd, hit);
      repeat (3) @(posedge ref_clk_i);
      chk(wd_cap, 32'h1234_ABC0 + b);
      chk(be_cap, 4'hF);
      chk(perr_cnt - p0, b == 1);
    end
  endtask
  task automatic t_decode();
    logic sel;
    for (int i = 0; i < 9; i++) begin
      sel = (cmds[i] == CMD_CFG_RD) || (cmds[i] == CMD_CFG_WR);
      u_host.xfer(cmds[i], sel ? 32'h10 : (BASE | 32'h8), 32'h5A, sel, 2'b00, rd, hit);
      chk(hit, 1'b1);
      chk(write_cap, cmds[i][0]);
      chk(cfg_cap, sel);
      chk(addr_cap, sel ? 32'h10 : (BASE | 32'h8));
    end
    u_host.xfer(CMD_CFG_RD, 32'h10, 32'h0, 1'b0, 2'b00, rd, hit);
    chk(hit, 1'b0);
    u_host.xfer(CMD_MEM_RD, BASE + 32'h100, 32'h0, 1'b0, 2'b00, rd, hit);
    chk(hit, 1'b0);
  endtask
  task automatic t_addr_par();
    int s0;
    for (int e = 0; e < 2; e++) begin
      s0 = serr_cnt;
      serr_en_i <= e[0];
      u_host.xfer(CMD_MEM_RD, BASE, 32'h0, 1'b0, 2'b01, rd, hit);
      repeat (2) @(posedge ref_clk_i);
      chk(serr_cnt - s0, e);
    end
  endtask
  task automatic t_irq();
    gnt_b_i <= 1'b0;
    irq_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({inta_oe_o, inta_b_o}, 2'b10);
    chk(req_oe_o, 1'b0);
    @(posedge ref_clk_i);
    irq_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(inta_oe_o, 1'b0);
    @(posedge ref_clk_i);
  endtask
  // reset lands in the middle of a read; the host finishes on its own bound
  task automatic t_reset_mid();
    fork
      u_host.xfer(CMD_MEM_RD, BASE, 32'h0, 1'b0, 2'b00, rd, hit);
    join_none
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    @(negedge ref_clk_i);
    chk({ad_oe_o, devsel_oe_o, trdy_oe_o, usr_req_o}, 4'h0);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (24) @(posedge ref_clk_i);
  endtask
  initial begin
    rst_b_i = 1'b0;
    irq_i = 1'b0;
    gnt_b_i = 1'b1;
    perr_en_i = 1'b1;
    serr_en_i = 1'b1;
    usr_stop_i = 1'b0;
    bar_base_i = BASE;
    usr_rdata_i = RDATA;
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_read(1'b0);
    t_read(1'b1);
    t_write();
    t_decode();
    t_addr_par();
    t_irq();
    t_reset_mid();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    test_done();
  end
endmodule
